// ==== iwt_bus_peer.sv ====
`timescale 1ns/1ps
// ****
// far bus party, clock only
// ****
module iwt_bus_peer (
    input  wire sclOe,   // design pulls clock low
    output wire sclLine  // resolved clock wire
);
    logic drvHigh = 1'b1;
    // wired-and: either party holds the line low
    assign sclLine = drvHigh & ~sclOe;
    task automatic clocks(input int n);
        #7;
        repeat (n) begin
            drvHigh = 0; #160; drvHigh = 1; #160;
        end
        drvHigh = 0; #160; drvHigh = 1;
    endtask
endmodule // iwt_bus_peer

// ==== iwt_defines.vh ====
`ifndef IWT_DEFINES_VH
`define IWT_DEFINES_VH

// interrupt timing register location and layout
`define IWT_REG_ADDR        16'hff63
`define IWT_REG_RESET       8'h00
`define IWT_BIT_WAIT_LO     0
`define IWT_BIT_WAIT_HI     1
`define IWT_BIT_WAIT_REL    2
`define IWT_BIT_CLK_CTRL    3
`define IWT_BIT_ADDR_ORDER  4
`define IWT_BIT_STOP_IRQ    5
`define IWT_BIT_CLK_LEVEL   6
`define IWT_WRITE_MASK      8'h3f

// wait select encodings
`define IWT_WAIT_8CLK       2'h2
`define IWT_WAIT_9CLK       2'h3
`define IWT_COUNT_8         4'h8
`define IWT_COUNT_9         4'h9

// event word cause codes
`define IWT_EVT_WIDTH       2
`define IWT_EVT_8CLK        2'h1
`define IWT_EVT_9CLK        2'h2
`define IWT_EVT_STOP        2'h3

`endif

// ==== iwt_pair_buffer.v ====
`timescale 1ns/1ps
// ****************************************************************
// two-entry buffer
// ****************************************************************
module iwt_pair_buffer #(
    parameter WIDTH = 2
) (
    input  wire             clk_sys,  // system clock
    input  wire             rstn,     // synchronous reset, active low
    input  wire [WIDTH-1:0] inData,   // word offered
    input  wire             inValid,  // word offered valid
    output wire             inReady,  // room for a word
    output reg  [WIDTH-1:0] outData,  // oldest word
    output wire             outValid, // oldest word valid
    input  wire             outReady  // drain accepts oldest word
);
    reg [WIDTH-1:0] second;
    reg [1:0]       fill;

    wire doPush = inValid && inReady;
    wire doPop  = outValid && outReady;

    assign inReady  = (fill != 2'h2);
    assign outValid = (fill != 2'h0);

    always @(posedge clk_sys) begin
        if (!rstn) begin
            outData <= {WIDTH{1'b0}};
            second  <= {WIDTH{1'b0}};
            fill    <= 2'h0;
        end else begin
            if (doPush && !doPop) begin
                fill <= fill + 2'h1;
                if (fill == 2'h0) begin
                    outData <= inData;
                end else begin
                    second <= inData;
                end
            end else if (doPop && !doPush) begin
                fill    <= fill - 2'h1;
                outData <= second;
            end else if (doPop && doPush) begin
                if (fill == 2'h1) begin
                    outData <= inData;
                end else begin
                    outData <= second;
                    second  <= inData;
                end
            end
        end
    end
endmodule // iwt_pair_buffer

// ==== iwt_wait_ctrl.v ====
`timescale 1ns/1ps
`include "iwt_defines.vh"

module iwt_wait_ctrl (
    input  wire                      clk_sys,           // system clock
    input  wire                      rstn,              // synchronous reset, active low
    input  wire [15:0]               cpuAddr,           // cpu address
    input  wire                      cpuWrByte,         // byte write strobe
    input  wire                      cpuWrBit,          // single-bit write strobe
    input  wire [2:0]                cpuBitSel,         // bit number for bit write
    input  wire [7:0]                cpuWrData,         // write data, bit value in bit 0
    input  wire                      cpuRd,             // read strobe
    output reg  [7:0]                cpuRdData,         // read data
    input  wire                      serialIfaceEnable, // serial interface on
    input  wire                      isMaster,          // this end is bus master
    input  wire                      xferActive,        // serial transfer in progress
    input  wire                      xferStart,         // transfer start pulse
    input  wire                      addrReceived,      // address received pulse
    input  wire                      stopDetected,      // stop condition pulse
    input  wire                      txOutputDisable,   // open-drain data output disable
    input  wire                      txBit,             // bit to place on data line
    input  wire                      masterClkLow,      // master clock generator low phase
    input  wire                      sclIn,             // clock pin level
    output wire                      sclOut,            // clock pin drive value
    output wire                      sclOe,             // clock pin drive enable
    output wire                      sdaOut,            // data pin drive value
    output wire                      sdaOe,             // data pin drive enable
    output reg                       busyMode,          // busy mode active
    output wire                      waitActive,        // clock held for wait
    output wire [`IWT_EVT_WIDTH-1:0] irqCause,          // serial interrupt cause
    output wire                      serialIrq,         // serial interrupt request valid
    input  wire                      irqReady           // interrupt consumer accepts
);
    // ****************************************************************
    // register
    // ****************************************************************
    reg  [7:0] timingReg;
    reg        sclMeta;
    reg        sclSync;
    reg        sclPrev;
    reg        disablePrev;
    reg        waitHold;
    reg  [3:0] edgeCount;
    reg  [`IWT_EVT_WIDTH-1:0] pendCause;
    reg        pendValid;
    reg  [7:0] next_timingReg;

    wire       regHit    = (cpuAddr == `IWT_REG_ADDR);
    wire       clockLevel = serialIfaceEnable & sclSync;
    wire [1:0] waitSel   = {timingReg[`IWT_BIT_WAIT_HI], timingReg[`IWT_BIT_WAIT_LO]};
    wire [7:0] readView  = {1'b0, clockLevel, timingReg[5:0]};

    function [3:0] waitCount;
        input [1:0] sel;
        begin
            if (sel == `IWT_WAIT_9CLK) begin
                waitCount = `IWT_COUNT_9;
            end else begin
                waitCount = `IWT_COUNT_8;
            end
        end
    endfunction

    always @* begin
        next_timingReg = timingReg;
        if (cpuWrByte && regHit) begin
            next_timingReg = (cpuWrData & `IWT_WRITE_MASK) |
                             (timingReg & ~`IWT_WRITE_MASK);
        end else if (cpuWrBit && regHit && cpuBitSel < 3'h6) begin
            next_timingReg[cpuBitSel] = cpuWrData[0];
        end
        // release clears once the hold has dropped; a fresh write of 1 wins
        if (timingReg[`IWT_BIT_WAIT_REL] && !waitHold &&
            !(regHit && cpuWrByte && cpuWrData[`IWT_BIT_WAIT_REL]) &&
            !(regHit && cpuWrBit && cpuBitSel == 3'h2 && cpuWrData[0])) begin
            next_timingReg[`IWT_BIT_WAIT_REL] = 1'b0;
        end
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            timingReg <= `IWT_REG_RESET;
            cpuRdData <= 8'h00;
        end else begin
            timingReg <= next_timingReg;
            if (cpuRd && regHit) begin
                cpuRdData <= readView;
            end else begin
                cpuRdData <= 8'h00;
            end
        end
    end

    // ****************************************************************
    // clock pin sampling and edge count
    // ****************************************************************
    wire sclRise = sclSync & ~sclPrev;
    wire sclFall = ~sclSync & sclPrev;
    wire [3:0] target = waitCount(waitSel);
    wire countHit = (edgeCount == target);
    wire riseHit  = sclRise && xferActive && (edgeCount + 4'h1 == target);
    wire selValid = waitSel[1];

    always @(posedge clk_sys) begin
        if (!rstn) begin
            sclMeta   <= 1'b1;
            sclSync   <= 1'b1;
            sclPrev   <= 1'b1;
            edgeCount <= 4'h0;
            waitHold  <= 1'b0;
        end else begin
            sclMeta <= sclIn;
            sclSync <= sclMeta;
            sclPrev <= sclSync;
            if (xferStart || !serialIfaceEnable) begin
                edgeCount <= 4'h0;
                waitHold  <= 1'b0;
            end else begin
                if (sclRise && xferActive && !countHit) begin
                    edgeCount <= edgeCount + 4'h1;
                end
                if (timingReg[`IWT_BIT_WAIT_REL] && waitHold) begin
                    waitHold  <= 1'b0;
                    edgeCount <= 4'h0;
                end else if (selValid && countHit && sclFall && !waitHold) begin
                    waitHold <= 1'b1;
                end
            end
        end
    end

    assign waitActive = waitHold;

    // ****************************************************************
    // interrupt events through the buffer
    // ****************************************************************
    wire stopEvt = stopDetected && timingReg[`IWT_BIT_STOP_IRQ];
    wire [`IWT_EVT_WIDTH-1:0] hitCause =
        (waitSel == `IWT_WAIT_9CLK) ? `IWT_EVT_9CLK : `IWT_EVT_8CLK;
    wire bufInReady;

    // one event that meets a full buffer waits here; further events arriving while it waits are lost
    always @(posedge clk_sys) begin
        if (!rstn) begin
            pendValid <= 1'b0;
            pendCause <= {`IWT_EVT_WIDTH{1'b0}};
        end else if (!pendValid || bufInReady) begin
            pendValid <= (selValid && riseHit) || stopEvt;
            pendCause <= (selValid && riseHit) ? hitCause : `IWT_EVT_STOP;
        end
    end

    iwt_pair_buffer #(
        .WIDTH (`IWT_EVT_WIDTH)
    ) eventBuf (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .inData   (pendCause),
        .inValid  (pendValid),
        .inReady  (bufInReady),
        .outData  (irqCause),
        .outValid (serialIrq),
        .outReady (irqReady)
    );

    // ****************************************************************
    // busy mode and pin drive
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (!rstn) begin
            busyMode    <= 1'b0;
            disablePrev <= 1'b0;
        end else begin
            disablePrev <= txOutputDisable;
            if (xferStart || addrReceived) begin
                busyMode <= 1'b0;
            end else if (txOutputDisable && !disablePrev) begin
                busyMode <= 1'b1;
            end
        end
    end

    // a held wait keeps the clock low even if the transfer flag drops
    wire sclDriveLow = serialIfaceEnable &&
                       (waitHold || (xferActive ? (isMaster && masterClkLow)
                                                : !timingReg[`IWT_BIT_CLK_CTRL]));
    assign sclOut = 1'b0;
    assign sclOe  = sclDriveLow;
    assign sdaOut = 1'b0;
    assign sdaOe  = serialIfaceEnable && !txOutputDisable && !busyMode && !txBit;

endmodule // iwt_wait_ctrl

// ==== iwt_wait_ctrl_assertions.sv ====
`timescale 1ns/1ps
`include "iwt_defines.vh"
// ****
// port checker
// ****
module iwt_wait_ctrl_chk (
    input wire        clk_sys,           // system clock
    input wire        rstn,              // synchronous reset, active low
    input wire [15:0] cpuAddr,           // cpu address
    input wire        cpuWrByte,         // byte write strobe
    input wire [7:0]  cpuWrData,         // write data
    input wire        cpuRd,             // read strobe
    input wire [7:0]  cpuRdData,         // read data
    input wire        serialIfaceEnable, // serial interface on
    input wire        xferStart,         // transfer start pulse
    input wire        addrReceived,      // address received pulse
    input wire        txOutputDisable,   // data output disable
    input wire        sclOe,             // clock pin drive enable
    input wire        sdaOe,             // data pin drive enable
    input wire        sdaOut,            // data pin drive value
    input wire        busyMode,          // busy mode active
    input wire        waitActive,        // clock held for wait
    input wire [1:0]  irqCause,          // interrupt cause
    input wire        serialIrq,         // interrupt valid
    input wire        irqReady           // interrupt accepted
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire regHit = cpuAddr == `IWT_REG_ADDR;
    a_sda_disable: assert property (txOutputDisable |-> !sdaOe && !sdaOut)
        else $error("data pin driven while disabled");
    a_off_quiet: assert property (!serialIfaceEnable |-> !sclOe && !sdaOe)
        else $error("pin driven while interface off");
    a_busy_leave: assert property ((xferStart || addrReceived) && $stable(txOutputDisable)
        |=> !busyMode) else $error("busy mode kept");
    a_read_unmapped: assert property (cpuRd && !regHit |=> cpuRdData == 8'h00)
        else $error("unmapped read not zero");
    a_top_bit: assert property (cpuRd |=> !cpuRdData[7]) else $error("bit 7 set");
    a_level_off: assert property (cpuRd && !serialIfaceEnable |=> !cpuRdData[6])
        else $error("clock level set while off");
    a_wait_hold: assert property (waitActive && serialIfaceEnable |-> sclOe)
        else $error("clock not held in wait");
    a_release_drop: assert property (waitActive && cpuWrByte && regHit && cpuWrData[2]
        |-> ##3 !waitActive) else $error("wait not released");
    a_start_unwait: assert property (xferStart |=> !waitActive) else $error("wait kept");
    a_irq_steady: assert property (serialIrq && !irqReady |=> serialIrq && $stable(irqCause))
        else $error("interrupt lost while stalled");
    a_irq_cause: assert property (serialIrq |-> irqCause != 2'h0)
        else $error("interrupt without cause");
    c_wait8: cover property (serialIrq && irqCause == `IWT_EVT_8CLK);
    c_wait9: cover property (serialIrq && irqCause == `IWT_EVT_9CLK);
    c_stop: cover property (serialIrq && irqCause == `IWT_EVT_STOP);
endmodule // iwt_wait_ctrl_chk
bind iwt_wait_ctrl iwt_wait_ctrl_chk chk (
    .clk_sys           (clk_sys),
    .rstn              (rstn),
    .cpuAddr           (cpuAddr),
    .cpuWrByte         (cpuWrByte),
    .cpuWrData         (cpuWrData),
    .cpuRd             (cpuRd),
    .cpuRdData         (cpuRdData),
    .serialIfaceEnable (serialIfaceEnable),
    .xferStart         (xferStart),
    .addrReceived      (addrReceived),
    .txOutputDisable   (txOutputDisable),
    .sclOe             (sclOe),
    .sdaOe             (sdaOe),
    .sdaOut            (sdaOut),
    .busyMode          (busyMode),
    .waitActive        (waitActive),
    .irqCause          (irqCause),
    .serialIrq         (serialIrq),
    .irqReady          (irqReady)
);

// ==== tb_i2c_wait_interrupt_timing.sv ====
`timescale 1ns/1ps
`include "iwt_defines.vh"
module tb_i2c_wait_interrupt_timing;
    logic [15:0] cpuAddr = 16'h0000;
    logic [7:0]  cpuWrData = 8'h00, cpuRdData;
    logic [2:0]  cpuBitSel = 3'h0;
    logic [1:0]  irqCause;
    logic clk_sys = 0, rstn = 0, cpuWrByte = 0, cpuWrBit = 0, cpuRd = 0, serialIfaceEnable = 0;
    logic isMaster = 0, xferActive = 0, xferStart = 0, addrReceived = 0, stopDetected = 0;
    logic txOutputDisable = 0, txBit = 0, masterClkLow = 0, irqReady = 0;
    logic sclOut, sclOe, sdaOut, sdaOe, busyMode, waitActive, serialIrq;
    wire  sclIn;
    int   fails = 0, total_checks = 0;
    iwt_wait_ctrl uut (
        .clk_sys           (clk_sys),
        .rstn              (rstn),
        .cpuAddr           (cpuAddr),
        .cpuWrByte         (cpuWrByte),
        .cpuWrBit          (cpuWrBit),
        .cpuBitSel         (cpuBitSel),
        .cpuWrData         (cpuWrData),
        .cpuRd             (cpuRd),
        .cpuRdData         (cpuRdData),
        .serialIfaceEnable (serialIfaceEnable),
        .isMaster          (isMaster),
        .xferActive        (xferActive),
        .xferStart         (xferStart),
        .addrReceived      (addrReceived),
        .stopDetected      (stopDetected),
        .txOutputDisable   (txOutputDisable),
        .txBit             (txBit),
        .masterClkLow      (masterClkLow),
        .sclIn             (sclIn),
        .sclOut            (sclOut),
        .sclOe             (sclOe),
        .sdaOut            (sdaOut),
        .sdaOe             (sdaOe),
        .busyMode          (busyMode),
        .waitActive        (waitActive),
        .irqCause          (irqCause),
        .serialIrq         (serialIrq),
        .irqReady          (irqReady)
    );
    iwt_bus_peer peer (.sclOe(sclOe), .sclLine(sclIn));
    initial forever #20 clk_sys = ~clk_sys;
    // ****
    // helpers
    // ****
    task automatic stp(input int n = 1); repeat (n) @(posedge clk_sys); #1; endtask
    task end_sim;
        if (fails == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic waitFor(input bit onHold);
        int i;
        for (i = 0; i < 400 && (onHold ? waitActive : serialIrq) !== 1'b1; i++) stp();
        if (i == 400) begin fails++; end_sim(); end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cpuAddr = a; cpuWrData = d; cpuWrByte = 1; stp(); cpuWrByte = 0;
    endtask
    task automatic wbit(input logic [2:0] b, input logic v);
        cpuBitSel = b; cpuWrData = {7'h00, v}; cpuWrBit = 1; stp(); cpuWrBit = 0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        cpuAddr = a; cpuRd = 1; stp(); cpuRd = 0; chk(cpuRdData, e);
    endtask
    task t_regs;
        rd(16'hff63, 8'h00);
        wr(16'hff63, 8'hff); stp(2); rd(16'hff63, 8'h3b);
        wbit(3'h3, 1'b0); rd(16'hff63, 8'h33);
        wr(16'hff62, 8'h00); rd(16'hff62, 8'h00); rd(16'hff63, 8'h33);
        wbit(3'h7, 1'b1); rd(16'hff63, 8'h33);
        rstn = 0; stp(2); rstn = 1; rd(16'hff63, 8'h00);
    endtask
    task t_idle;
        serialIfaceEnable = 1; stp(4); chk(sclOe, 8'h01);
        wbit(3'h3, 1'b1); chk(sclOe, 8'h00); stp(3); rd(16'hff63, 8'h48);
    endtask
    task t_busy;
        xferActive = 1; stp(); chk(sdaOe, 8'h01);
        txOutputDisable = 1; stp(2); chk({busyMode, sdaOe}, 8'h02);
        addrReceived = 1; stp(); addrReceived = 0; stp(); chk(busyMode, 8'h00);
        txOutputDisable = 0; xferActive = 0;
    endtask
    task automatic t_wait(input logic [1:0] sel, input logic m);
        isMaster = m; wr(16'hff63, {5'h01, 1'b0, sel});
        xferActive = 1; xferStart = 1; stp(); xferStart = 0;
        peer.clocks(sel == `IWT_WAIT_8CLK ? 8 : 9);
        waitFor(1'b0);
        chk(irqCause, sel == `IWT_WAIT_8CLK ? `IWT_EVT_8CLK : `IWT_EVT_9CLK);
        irqReady = 1; stp(); irqReady = 0;
        waitFor(1'b1); stp(8); chk({sclIn, sclOut, sclOe}, 8'h01);
        rd(16'hff63, {5'h01, 1'b0, sel});
        wr(16'hff63, {5'h01, 1'b1, sel}); stp(2); chk(waitActive, 8'h00);
        stp(4); rd(16'hff63, 8'h48 | sel);
        masterClkLow = 1; stp(); chk(sclOe, {7'h00, m});
        masterClkLow = 0; stp(4);
        xferActive = 0;
    endtask
    task t_stop;
        int n;
        wbit(3'h5, 1'b0); stopDetected = 1; stp(); stopDetected = 0;
        stp(4); chk(serialIrq, 8'h00);
        wbit(3'h5, 1'b1);
        repeat (4) begin stopDetected = 1; stp(); stopDetected = 0; stp(); end
        stp(4); n = 0; irqReady = 1;
        repeat (12) begin
            if (serialIrq === 1'b1) begin n++; chk(irqCause, `IWT_EVT_STOP); end
            stp();
        end
        irqReady = 0; chk(n[7:0], 8'h03);
    endtask
    initial begin
        stp(4); rstn = 1;
        t_regs(); t_idle(); t_busy();
        t_wait(`IWT_WAIT_8CLK, 0); t_wait(`IWT_WAIT_9CLK, 0);
        t_wait(`IWT_WAIT_8CLK, 1); t_wait(`IWT_WAIT_9CLK, 1);
        t_stop(); end_sim();
    end
endmodule // tb_i2c_wait_interrupt_timing
